// ### core/sram_ctrl.sv
// Controller that drives an asynchronous 64K x 4 static memory over its pins.
// Assumes the memory sits on the pins directly; read data arrives asynchronously.
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl
    import sram_ctrl_pkg::*;
#(
    parameter int unsigned READ_WAIT  = READ_WAIT_CYCLES,
    parameter int unsigned WRITE_WAIT = WRITE_PULSE_CYCLES,
    parameter int unsigned FLOAT_WAIT = FLOAT_WAIT_CYCLES
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // User request side
    input  wire logic                  req_valid,
    input  wire request_type           req,
    output logic                       req_ready,
    output logic                       rsp_valid,
    output logic [DATA_WIDTH-1:0]      rsp_rdata,
    // Memory pins
    output pins_type                   pins,
    input  wire logic [DATA_WIDTH-1:0] data_lines_in,
    output logic [DATA_WIDTH-1:0]      data_lines_out,
    output logic [DATA_WIDTH-1:0]      data_lines_oe_n
);

    typedef enum logic [2:0] {IDLE, RD_WAIT, WR_SETUP, WR_PULSE, WR_HOLD, TURN} state_type;

    logic                  rst_meta_q;
    logic                  rst_sync_q;
    state_type             state_q;
    logic [CNT_WIDTH-1:0]  cnt_q;
    logic [DATA_WIDTH-1:0] din_s1_q;
    logic [DATA_WIDTH-1:0] din_s2_q;
    logic [DATA_WIDTH-1:0] din_s3_q;
    logic                  cnt_done;

    assign cnt_done = (cnt_q == '0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Read data sampling; the value counts once the second and third stages agree
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            din_s1_q <= DATA_RESET;
            din_s2_q <= DATA_RESET;
            din_s3_q <= DATA_RESET;
        end
        else
        begin
            din_s1_q <= data_lines_in;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
        end
    end

    // Sequencer
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            unique case (state_q)
                IDLE:
                begin
                    if (req_valid && req_ready)
                    begin
                        if (req.write)
                        begin
                            state_q <= WR_SETUP;
                            cnt_q   <= '0;
                        end
                        else
                        begin
                            state_q <= RD_WAIT;
                            cnt_q   <= CNT_WIDTH'(READ_WAIT + SAMPLE_FLOPS);
                        end
                    end
                end
                RD_WAIT:
                begin
                    if (cnt_done && (din_s2_q == din_s3_q))
                    begin
                        state_q <= TURN;
                        cnt_q   <= CNT_WIDTH'(FLOAT_WAIT);
                    end
                    else if (!cnt_done)
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                WR_SETUP:
                begin
                    state_q <= WR_PULSE;
                    cnt_q   <= CNT_WIDTH'(WRITE_WAIT - 1);
                end
                WR_PULSE:
                begin
                    if (cnt_done)
                    begin
                        state_q <= WR_HOLD;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                WR_HOLD:
                begin
                    state_q <= TURN;
                    cnt_q   <= CNT_WIDTH'(FLOAT_WAIT);
                end
                TURN:
                begin
                    if (cnt_done)
                    begin
                        state_q <= IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Pin drive: address set no later than selects fall and held through the end of access
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            pins.chip_select_a_n <= 1'b1;
            pins.chip_select_b_n <= 1'b1;
            pins.write_strobe_n  <= 1'b1;
            pins.output_gate_n   <= 1'b1;
            pins.address_lines   <= ADDR_RESET;
            data_lines_out       <= DATA_RESET;
            data_lines_oe_n      <= '1;
        end
        else
        begin
            unique case (state_q)
                IDLE:
                begin
                    if (req_valid && req_ready)
                    begin
                        pins.address_lines <= req.addr;
                        data_lines_out     <= req.wdata;
                        pins.output_gate_n <= req.write;
                        if (!req.write)
                        begin
                            pins.chip_select_a_n <= 1'b0;
                            pins.chip_select_b_n <= 1'b0;
                        end
                    end
                end
                WR_SETUP:
                begin
                    pins.chip_select_a_n <= 1'b0;
                    pins.chip_select_b_n <= 1'b0;
                    pins.write_strobe_n  <= 1'b0;
                    data_lines_oe_n      <= '0;
                end
                WR_PULSE:
                begin
                    if (cnt_done)
                    begin
                        pins.write_strobe_n  <= 1'b1;
                        pins.chip_select_a_n <= 1'b1;
                        pins.chip_select_b_n <= 1'b1;
                    end
                end
                WR_HOLD:
                begin
                    data_lines_oe_n <= '1;
                end
                RD_WAIT:
                begin
                    if (cnt_done && (din_s2_q == din_s3_q))
                    begin
                        pins.chip_select_a_n <= 1'b1;
                        pins.chip_select_b_n <= 1'b1;
                        pins.output_gate_n   <= 1'b1;
                    end
                end
                TURN:
                begin
                end
            endcase
        end
    end

    // User side handshake and read return
    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= DATA_RESET;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (state_q == IDLE && req_valid && req_ready)
            begin
                req_ready <= 1'b0;
            end
            else if (state_q == TURN && cnt_done)
            begin
                req_ready <= 1'b1;
            end
            else if (state_q == IDLE)
            begin
                req_ready <= 1'b1;
            end
            if (state_q == RD_WAIT && cnt_done && (din_s2_q == din_s3_q))
            begin
                rsp_valid <= 1'b1;
                rsp_rdata <= din_s3_q;
            end
        end
    end

endmodule : sram_ctrl
`default_nettype wire

// ### core/sram_ctrl_pkg.sv
// Constants and carrier types for the asynchronous 64K x 4 static memory controller.
// Assumes a 125 MHz system clock; timing figures are for the selected speed grade.
// Operation
// - Write starts only with all signals low, ends when any goes high.
// - Controller meets data setup and hold to the edge ending the write.
// - Strobe write with gate low lasts at least float delay plus data setup.
// - Controller presents valid address no later than the selects falling.
package sram_ctrl_pkg;

    localparam int unsigned ADDR_WIDTH = 16;
    localparam int unsigned DATA_WIDTH = 4;
    localparam int unsigned CLK_PERIOD_NS = 8;

    // Speed-grade figures in ns (12 ns grade)
    localparam int unsigned ACCESS_TIME_NS               = 12;
    localparam int unsigned WRITE_PULSE_NS               = 8;
    localparam int unsigned WRITE_DATA_SETUP_TIME_NS     = 8;
    localparam int unsigned STROBE_LOW_TO_FLOAT_DELAY_NS = 7;
    localparam int unsigned SELECT_HIGH_TO_FLOAT_NS      = 5;

    // Least times, rounded up to whole cycles, at least one
    function automatic int unsigned ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    // Read wait covers access time; the controller adds the three-flop input sampling path
    localparam int unsigned READ_WAIT_CYCLES  = ns_to_cycles(ACCESS_TIME_NS);
    localparam int unsigned WRITE_PULSE_CYCLES =
        ns_to_cycles(((STROBE_LOW_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_TIME_NS)
            > WRITE_PULSE_NS) ? (STROBE_LOW_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_TIME_NS)
            : WRITE_PULSE_NS);
    localparam int unsigned FLOAT_WAIT_CYCLES  = ns_to_cycles(SELECT_HIGH_TO_FLOAT_NS);
    localparam int unsigned SAMPLE_FLOPS       = 3;
    localparam int unsigned CNT_WIDTH          = 4;

    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 4'h0;

    typedef struct packed {
        logic                  write;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } request_type;

    typedef struct packed {
        logic                  chip_select_a_n;
        logic                  chip_select_b_n;
        logic                  write_strobe_n;
        logic                  output_gate_n;
        logic [ADDR_WIDTH-1:0] address_lines;
    } pins_type;

endpackage : sram_ctrl_pkg

// ### bench/sram_ctrl_chk.sv
// Pin-protocol checker for the static memory controller.
// Assumes it is bound into sram_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_chk
    import sram_ctrl_pkg::*;
#(
    parameter int unsigned WRITE_WAIT = WRITE_PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // User side
    input wire logic                  req_valid,
    input wire request_type           req,
    input wire logic                  req_ready,
    input wire logic                  rsp_valid,
    input wire logic [DATA_WIDTH-1:0] rsp_rdata,
    // Memory pins
    input wire pins_type              pins,
    input wire logic [DATA_WIDTH-1:0] data_lines_in,
    input wire logic [DATA_WIDTH-1:0] data_lines_out,
    input wire logic [DATA_WIDTH-1:0] data_lines_oe_n
);
    logic       sel;
    logic       wr;
    logic [3:0] wlen_q;
    assign sel = !pins.chip_select_a_n && !pins.chip_select_b_n;
    assign wr  = sel && !pins.write_strobe_n;
    // Length of the current write overlap in cycles
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wlen_q <= 4'h0;
        else if (!wr)
            wlen_q <= 4'h0;
        else if (wlen_q != 4'hf)
            wlen_q <= wlen_q + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    pulse_len_a: assert property ($rose(pins.write_strobe_n) |-> wlen_q >= WRITE_WAIT)
        else $error("write pulse shorter than required");
    sel_pair_a: assert property (pins.chip_select_a_n == pins.chip_select_b_n)
        else $error("selects differ");
    strobe_sel_a: assert property (!pins.write_strobe_n |-> sel && pins.output_gate_n)
        else $error("strobe low outside selection or gate low");
    end_same_a: assert property ($rose(pins.write_strobe_n) |-> $rose(pins.chip_select_a_n))
        else $error("strobe and selects did not end together");
    data_hold_a: assert property ($rose(pins.write_strobe_n)
        |-> data_lines_oe_n == 4'h0 && $stable(data_lines_out))
        else $error("write data not held past write end");
    data_setup_a: assert property (wr |-> data_lines_oe_n == 4'h0 && $stable(data_lines_out))
        else $error("write data moved during write");
    addr_hold_a: assert property (sel && $past(sel) |-> $stable(pins.address_lines))
        else $error("address moved while selected");
    no_clash_a: assert property (sel && pins.write_strobe_n |-> data_lines_oe_n == 4'hf)
        else $error("controller drives during read");
    take_busy_a: assert property (req_valid && req_ready |=> !req_ready)
        else $error("ready stayed high after take");
    // Returned word is the line value four edges back, once two samples agreed
    read_sample_a: assert property (rsp_valid |-> rsp_rdata == $past(data_lines_in, 4))
        else $error("read data differs from the sampled line value");
    cover property ($rose(pins.write_strobe_n));
    cover property (rsp_valid);
    cover property (req_valid && req_ready ##[1:20] req_valid && req_ready);
endmodule : sram_ctrl_chk
bind sram_ctrl sram_ctrl_chk #(.WRITE_WAIT(WRITE_WAIT)) chk_u (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .pins(pins), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
`default_nettype wire

// ### bench/sram_model.sv
// Behavioural model of the 64K x 4 asynchronous static memory.
// Assumes the controller pins reach it directly; released lines show a toggling pattern.
`timescale 1ns/10ps
`default_nettype none
module sram_model
    import sram_ctrl_pkg::*;
(
    // Memory pins
    input  wire pins_type              pins,
    input  wire logic [DATA_WIDTH-1:0] data_lines_out,
    input  wire logic [DATA_WIDTH-1:0] data_lines_oe_n,
    output logic [DATA_WIDTH-1:0]      data_lines_in
);
    int unsigned           acc_ns = ACCESS_TIME_NS;
    logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];
    logic                  sel;
    logic                  wr;
    logic                  drv;
    logic                  standby;
    logic                  drv_d = 1'b0;
    logic [DATA_WIDTH-1:0] rd_d = 4'h0;
    logic [DATA_WIDTH-1:0] flt;
    assign sel = !pins.chip_select_a_n && !pins.chip_select_b_n;
    assign standby = !sel;
    assign wr = sel && !pins.write_strobe_n;
    assign drv = sel && pins.write_strobe_n && !pins.output_gate_n;
    assign data_lines_in = drv_d ? rd_d : flt;
    always @(negedge wr)
    begin
        mem[pins.address_lines] = (data_lines_oe_n == 4'h0) ? data_lines_out : ~flt;
        rd_d <= #(acc_ns) mem[pins.address_lines];
    end
    always @(pins.address_lines) rd_d <= #(acc_ns) mem[pins.address_lines];
    always @(drv) drv_d <= #(drv ? acc_ns : SELECT_HIGH_TO_FLOAT_NS) drv;
    // Undriven lines change every cycle so stale values never look stable
    initial
    begin
        flt = 4'ha;
        #3;
        forever
        begin
            #8;
            flt = ~flt;
        end
    end
endmodule : sram_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench: controller driving the behavioural static memory model.
// Assumes the default speed-grade parameters of the controller package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) begin check_count++; if ((exp) !== (got)) begin miscompares++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end
module tb
    import sram_ctrl_pkg::*;
();
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  req_valid = 1'b0;
    request_type           req = '0;
    logic                  req_ready;
    logic                  rsp_valid;
    logic [DATA_WIDTH-1:0] rsp_rdata;
    pins_type              pins;
    logic [DATA_WIDTH-1:0] din;
    logic [DATA_WIDTH-1:0] dout;
    logic [DATA_WIDTH-1:0] doe_n;
    int                    miscompares = 0;
    int                    check_count = 0;
    always #4 clk = ~clk;
    sram_ctrl dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
        .data_lines_in(din), .data_lines_out(dout), .data_lines_oe_n(doe_n));
    sram_model mem_u (.pins(pins), .data_lines_out(dout), .data_lines_oe_n(doe_n),
        .data_lines_in(din));
    task automatic stop_test();
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // Entered at a falling edge; returns at the falling edge where ready is back
    task automatic access(input logic w, input logic [15:0] a, input logic [3:0] d,
                          output logic [3:0] q);
        int n;
        n = 0;
        q = 'x;
        req_valid = 1'b1;
        req = '{w, a, d};
        while (req_ready !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while (req_ready !== 1'b1 && n < 80)
        begin
            if (rsp_valid === 1'b1)
                q = rsp_rdata;
            @(negedge clk);
            n++;
        end
    endtask : access
    task automatic check_bounds();
        logic [15:0] a [4] = '{16'h0000, 16'hffff, 16'h5a5a, 16'ha5a5};
        logic [3:0]  d [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
        logic [3:0]  q;
        foreach (a[i]) access(1'b1, a[i], d[i], q);
        foreach (a[i])
        begin
            access(1'b0, a[i], 4'h0, q);
            `CHK("read data", d[i], q)
            `CHK("stored word", d[i], mem_u.mem[a[i]])
        end
    endtask : check_bounds
    task automatic check_overwrite_slow();
        logic [3:0] q;
        access(1'b1, 16'h1234, 4'h3, q);
        access(1'b1, 16'h1234, 4'hc, q);
        access(1'b1, 16'h1235, 4'h6, q);
        access(1'b0, 16'h1234, 4'h0, q);
        `CHK("overwritten word", 4'hc, q)
        mem_u.acc_ns = 30;
        access(1'b0, 16'hffff, 4'h0, q);
        `CHK("slow read", 4'ha, q)
        mem_u.acc_ns = ACCESS_TIME_NS;
    endtask : check_overwrite_slow
    task automatic check_no_drive();
        logic [3:0] q;
        fork
            access(1'b1, 16'h0777, 4'h9, q);
            repeat (10)
            begin
                @(negedge clk);
                `CHK("model drive", 1'b0, mem_u.drv_d)
            end
        join
        `CHK("gated write", 4'h9, mem_u.mem[16'h0777])
    endtask : check_no_drive
    task automatic check_reset();
        logic [3:0] q;
        req_valid = 1'b1;
        req = '{1'b0, 16'h0000, 4'h0};
        repeat (3) @(negedge clk);
        rst_n = 1'b0;
        req_valid = 1'b0;
        @(negedge clk);
        `CHK("model standby", 1'b1, mem_u.standby)
        `CHK("enables in reset", 4'hf, doe_n)
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        access(1'b0, 16'h0000, 4'h0, q);
        `CHK("kept word", 4'h5, q)
    endtask : check_reset
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        check_bounds();
        check_overwrite_slow();
        check_no_drive();
        check_reset();
        stop_test();
    end
endmodule : tb
`default_nettype wire
